// ---- hdl/sha_alu_map.vh ----
`ifndef SHA_ALU_MAP_VH
`define SHA_ALU_MAP_VH

// ----------------------------------------
// operation codes
// ----------------------------------------
`define SHA_OP_W 4
`define SHA_OP_HALF_ADDSUB_X 4'h0
`define SHA_OP_HALF_SUBADD_X 4'h1
`define SHA_OP_HALF_SUB_HW 4'h2
`define SHA_OP_HALF_SUB_BY 4'h3
`define SHA_OP_SUB_HW 4'h4
`define SHA_OP_SUB_BY 4'h5
`define SHA_OP_ADDSUB_X 4'h6
`define SHA_OP_SUBADD_X 4'h7
`define SHA_OP_TEST_AND 4'h8
`define SHA_OP_TEST_XOR 4'h9
`define SHA_OP_ADD_HW 4'hA
`define SHA_OP_ADD_BY 4'hB

// ----------------------------------------
// lane layout
// ----------------------------------------
`define SHA_HI 31:16
`define SHA_LO 15:0
`define SHA_SIGN 31
`define SHA_REG_W 4
`define SHA_HW_W 16
`define SHA_BY_W 8
`endif

// ---- hdl/sha_lane.v ----
`include "sha_alu_map.vh"
// one lane of width W: add or subtract, optionally halved
module sha_lane #(
    parameter W = 8
) (
    input wire [W-1:0] a,
    input wire [W-1:0] b,
    input wire sub,
    input wire halve,
    input wire sgn,
    output wire [W-1:0] y
);
    wire [W:0] ax;
    wire [W:0] bx;
    wire [W:0] s;
    // one extra bit so the halved value never overflows
    assign ax = {sgn & a[W-1], a};
    assign bx = {sgn & b[W-1], b};
    assign s = sub ? (ax - bx) : (ax + bx);
    // wraps inside the lane, no carry leaves it
    assign y = halve ? s[W:1] : s[W-1:0];
endmodule

// ---- hdl/sha_alu.v ----
`include "sha_alu_map.vh"
module sha_alu (
    ref_clk,
    rst_n,
    clk_en,
    issue,
    cond_pass,
    op,
    first_idx,
    rd_idx,
    rd_given,
    op_a,
    op_b,
    shift_carry,
    flag_v_in,
    result_q,
    wr_en_q,
    wr_idx_q,
    flags_we_q,
    flag_n_q,
    flag_z_q,
    flag_c_q,
    flag_v_q
);
    // ----------------------------------------
    // parameters
    // ----------------------------------------
    parameter DW = 32;
    parameter HW = `SHA_HW_W;
    parameter BW = `SHA_BY_W;
    localparam NHW = DW / HW;
    localparam NBY = DW / BW;

    // ----------------------------------------
    // inputs
    // ----------------------------------------
    input wire ref_clk;
    input wire rst_n;
    input wire clk_en;
    input wire issue;
    input wire cond_pass;
    input wire [`SHA_OP_W-1:0] op;
    input wire [`SHA_REG_W-1:0] first_idx;
    input wire [`SHA_REG_W-1:0] rd_idx;
    input wire rd_given;
    input wire [DW-1:0] op_a;
    input wire [DW-1:0] op_b;
    input wire shift_carry;
    input wire flag_v_in;

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    output reg [DW-1:0] result_q;
    output reg wr_en_q;
    output reg [`SHA_REG_W-1:0] wr_idx_q;
    output reg flags_we_q;
    output reg flag_n_q;
    output reg flag_z_q;
    output reg flag_c_q;
    output reg flag_v_q;

    // ----------------------------------------
    // operation decode
    // ----------------------------------------
    // exchange forms pair a.hi with b.lo and a.lo with b.hi, except SHA_OP_ADDSUB_X, which pairs a.hi with b.lo in both lanes
    reg [DW-1:0] a_lane;
    reg [DW-1:0] b_lane;
    reg sub_hi;
    reg sub_lo;
    reg sub_by;
    reg halve;
    reg sgn;
    reg bytes;
    reg is_test;
    reg is_xor;
    reg known;

    always @* begin
        a_lane = op_a;
        b_lane = op_b;
        sub_hi = 1'b0;
        sub_lo = 1'b0;
        sub_by = 1'b0;
        halve = 1'b0;
        sgn = 1'b1;
        bytes = 1'b0;
        is_test = 1'b0;
        is_xor = 1'b0;
        known = 1'b1;
        case (op)
            `SHA_OP_HALF_ADDSUB_X: begin
                b_lane = {op_b[`SHA_LO], op_b[`SHA_HI]};
                sub_lo = 1'b1;
                halve = 1'b1;
            end
            `SHA_OP_HALF_SUBADD_X: begin
                b_lane = {op_b[`SHA_LO], op_b[`SHA_HI]};
                sub_hi = 1'b1;
                halve = 1'b1;
            end
            `SHA_OP_HALF_SUB_HW: begin
                sub_hi = 1'b1;
                sub_lo = 1'b1;
                halve = 1'b1;
            end
            `SHA_OP_HALF_SUB_BY: begin
                sub_by = 1'b1;
                halve = 1'b1;
                bytes = 1'b1;
            end
            `SHA_OP_SUB_HW: begin
                sub_hi = 1'b1;
                sub_lo = 1'b1;
            end
            `SHA_OP_SUB_BY: begin
                sub_by = 1'b1;
                bytes = 1'b1;
            end
            `SHA_OP_ADDSUB_X: begin
                // both lanes read a.hi and b.lo; only the lower one subtracts
                a_lane = {op_a[`SHA_HI], op_a[`SHA_HI]};
                b_lane = {op_b[`SHA_LO], op_b[`SHA_LO]};
                sub_lo = 1'b1;
            end
            `SHA_OP_SUBADD_X: begin
                b_lane = {op_b[`SHA_LO], op_b[`SHA_HI]};
                sub_lo = 1'b1;
            end
            `SHA_OP_ADD_HW: begin
                sgn = 1'b0;
            end
            `SHA_OP_ADD_BY: begin
                sgn = 1'b0;
                bytes = 1'b1;
            end
            `SHA_OP_TEST_AND: begin
                is_test = 1'b1;
            end
            `SHA_OP_TEST_XOR: begin
                is_test = 1'b1;
                is_xor = 1'b1;
            end
            default: begin
                // spare codes neither write a register nor touch the flags
                known = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // lane arithmetic
    // ----------------------------------------
    // both lane sets run every cycle; cheaper than sharing adders across widths
    wire [DW-1:0] y16;
    wire [DW-1:0] y8;
    genvar g;

    generate
        // the upper halfword lane is the last index
        for (g = 0; g < NHW; g = g + 1) begin : hw
            sha_lane #(
                .W(HW)
            ) u_lane (
                .a(a_lane[HW*g+HW-1:HW*g]),
                .b(b_lane[HW*g+HW-1:HW*g]),
                .sub((g == NHW - 1) ? sub_hi : sub_lo),
                .halve(halve),
                .sgn(sgn),
                .y(y16[HW*g+HW-1:HW*g])
            );
        end

        // byte lanes never see the exchange remap
        for (g = 0; g < NBY; g = g + 1) begin : by
            sha_lane #(
                .W(BW)
            ) u_lane (
                .a(op_a[BW*g+BW-1:BW*g]),
                .b(op_b[BW*g+BW-1:BW*g]),
                .sub(sub_by),
                .halve(halve),
                .sgn(sgn),
                .y(y8[BW*g+BW-1:BW*g])
            );
        end
    endgenerate

    // ----------------------------------------
    // result select
    // ----------------------------------------
    // one lane set is kept, the other is dropped
    reg [DW-1:0] lane_res;
    always @* begin
        case (bytes)
            1'b1: lane_res = y8;
            default: lane_res = y16;
        endcase
    end

    // ----------------------------------------
    // test operations
    // ----------------------------------------
    // the value only feeds the flags and is never written back
    wire [DW-1:0] tval;
    assign tval = is_xor ? (op_a ^ op_b) : (op_a & op_b);

    // ----------------------------------------
    // zero detect
    // ----------------------------------------
    // per-byte reduction keeps the zero tree shallow
    wire [NBY-1:0] tzero;
    generate
        for (g = 0; g < NBY; g = g + 1) begin : zb
            assign tzero[g] = ~|tval[BW*g+BW-1:BW*g];
        end
    endgenerate

    // ----------------------------------------
    // test flags
    // ----------------------------------------
    // carry comes from the operand shifter outside; overflow is passed back
    reg tflag_n;
    reg tflag_z;
    reg tflag_c;
    reg tflag_v;
    always @* begin
        tflag_n = tval[`SHA_SIGN];
        tflag_z = &tzero;
        tflag_c = shift_carry;
        tflag_v = flag_v_in;
    end

    // ----------------------------------------
    // acceptance
    // ----------------------------------------
    // a failed condition leaves both registers and flags untouched
    wire go;
    assign go = issue & cond_pass & known;
    wire do_write;
    wire do_flags;
    assign do_write = go & ~is_test;
    assign do_flags = go & is_test;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    reg [DW-1:0] result_d;
    reg wr_en_d;
    reg [`SHA_REG_W-1:0] wr_idx_d;
    reg flags_we_d;
    reg flag_n_d;
    reg flag_z_d;
    reg flag_c_d;
    reg flag_v_d;

    // an idle cycle keeps every value and drops both pulses
    always @* begin
        result_d = result_q;
        wr_en_d = do_write;
        wr_idx_d = wr_idx_q;
        flags_we_d = do_flags;
        flag_n_d = flag_n_q;
        flag_z_d = flag_z_q;
        flag_c_d = flag_c_q;
        flag_v_d = flag_v_q;
        if (do_write) begin
            result_d = lane_res;
            // caller keeps stack pointer and program counter out; no check here
            wr_idx_d = rd_given ? rd_idx : first_idx;
        end

        if (do_flags) begin
            flag_n_d = tflag_n;
            flag_z_d = tflag_z;
            flag_c_d = tflag_c;
            flag_v_d = tflag_v;
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // reset wins over the clock enable so a frozen core can still be cleared
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            result_q <= {DW{1'b0}};
            wr_en_q <= 1'b0;
            wr_idx_q <= {`SHA_REG_W{1'b0}};
            flags_we_q <= 1'b0;
            flag_n_q <= 1'b0;
            flag_z_q <= 1'b0;
            flag_c_q <= 1'b0;
            flag_v_q <= 1'b0;
        end else if (clk_en) begin
            result_q <= result_d;
            wr_en_q <= wr_en_d;
            wr_idx_q <= wr_idx_d;
            flags_we_q <= flags_we_d;
            flag_n_q <= flag_n_d;
            flag_z_q <= flag_z_d;
            flag_c_q <= flag_c_d;
            flag_v_q <= flag_v_d;
        end
    end
endmodule

// ---- tb/sha_alu_chk_assertions.sv ----
module sha_alu_chk (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire issue,
    input wire cond_pass,
    input wire [3:0] op,
    input wire [31:0] op_a,
    input wire [31:0] op_b,
    input wire flag_v_in,
    input wire [31:0] result_q,
    input wire wr_en_q,
    input wire flags_we_q,
    input wire flag_n_q,
    input wire flag_v_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_go; clk_en && issue && cond_pass; endsequence
    sequence s_tst; s_go ##0 (op == 4'h8 || op == 4'h9); endsequence
    sequence s_pk; s_go ##0 (op < 4'h8 || op == 4'ha || op == 4'hb); endsequence
    property p_cnd; clk_en && issue && !cond_pass |=> !wr_en_q && !flags_we_q; endproperty
    a_cnd: assert property (p_cnd) else $error("op ran without condition");
    property p_pk; s_pk |=> wr_en_q && !flags_we_q; endproperty
    a_pk: assert property (p_pk) else $error("packed op write or flags wrong");
    property p_tst; s_tst |=> flags_we_q && !wr_en_q; endproperty
    a_tst: assert property (p_tst) else $error("test op wrote a register");
    property p_eqn; s_go ##0 op == 4'h9 |=> flag_n_q == $past(op_a[31] ^ op_b[31]); endproperty
    a_eqn: assert property (p_eqn) else $error("xor test sign flag wrong");
    property p_andn; s_go ##0 op == 4'h8 |=> flag_n_q == $past(op_a[31] & op_b[31]); endproperty
    a_andn: assert property (p_andn) else $error("and test sign flag wrong");
    property p_v; s_tst |=> flag_v_q == $past(flag_v_in); endproperty
    a_v: assert property (p_v) else $error("test changed overflow");
    property p_s16; s_go ##0 op == 4'h4 |=> result_q[15:0] == $past(op_a[15:0] - op_b[15:0]);
    endproperty
    a_s16: assert property (p_s16) else $error("halfword difference wrong");
    property p_u8; s_go ##0 op == 4'hb |=> result_q[7:0] == $past(op_a[7:0] + op_b[7:0]);
    endproperty
    a_u8: assert property (p_u8) else $error("byte sum wrong");
endmodule
bind sha_alu sha_alu_chk u_chk (.ref_clk, .rst_n, .clk_en, .issue, .cond_pass, .op, .op_a,
    .op_b, .flag_v_in, .result_q, .wr_en_q, .flags_we_q, .flag_n_q, .flag_v_q);

// ---- tb/sha_rf_model.sv ----
// register file and status flags fed back from the datapath
module sha_rf_model (
    input wire ref_clk,
    input wire wr_en_q,
    input wire [3:0] wr_idx_q,
    input wire [31:0] result_q,
    input wire flags_we_q,
    input wire [3:0] flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [16];
    logic [3:0] psr = 4'h0;
    int nw = 0;
    int nf = 0;
    always @(posedge ref_clk) begin
        if (wr_en_q) begin
            regs[wr_idx_q] <= result_q;
            nw <= nw + 1;
        end
        if (flags_we_q) begin
            psr <= flags;
            nf <= nf + 1;
        end
    end
endmodule

// ---- tb/tb_sha_alu.sv ----
module tb_sha_alu;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, clk_en = 1, issue = 0, cond_pass = 0, rd_given = 0;
    logic shift_carry = 0, flag_v_in = 0;
    logic [3:0] op = 0, first_idx = 0, rd_idx = 0, wr_idx_q;
    logic [31:0] op_a = 0, op_b = 0, result_q;
    logic wr_en_q, flags_we_q, flag_n_q, flag_z_q, flag_c_q, flag_v_q;
    int err_total = 0;
    int checks = 0;
    logic [31:0] exp_q[$];
    sha_alu dut (.ref_clk, .rst_n, .clk_en, .issue, .cond_pass, .op, .first_idx, .rd_idx,
        .rd_given, .op_a, .op_b, .shift_carry, .flag_v_in, .result_q, .wr_en_q, .wr_idx_q,
        .flags_we_q, .flag_n_q, .flag_z_q, .flag_c_q, .flag_v_q);
    sha_rf_model rf (.ref_clk, .wr_en_q, .wr_idx_q, .result_q, .flags_we_q,
        .flags({flag_n_q, flag_z_q, flag_c_q, flag_v_q}));
    initial forever #5 ref_clk = ~ref_clk;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [31:0] mdl(input logic [3:0] o, input logic [31:0] a, b);
        int ah, al, bh, bl;
        logic [31:0] r;
        ah = $signed(a[31:16]);
        al = $signed(a[15:0]);
        bh = $signed(b[31:16]);
        bl = $signed(b[15:0]);
        r = 32'h0;
        case (o)
            4'h0: r = {16'((ah + bl) >>> 1), 16'((al - bh) >>> 1)};
            4'h1: r = {16'((ah - bl) >>> 1), 16'((al + bh) >>> 1)};
            4'h2: r = {16'((ah - bh) >>> 1), 16'((al - bl) >>> 1)};
            4'h4: r = {16'(ah - bh), 16'(al - bl)};
            4'h6: r = {16'(ah + bl), 16'(ah - bl)};
            4'h7: r = {16'(ah + bl), 16'(al - bh)};
            4'ha: r = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
            default: for (int i = 0; i < 32; i += 8) begin
                if (o == 4'h3) r[i+:8] = 8'((int'($signed(a[i+:8])) - $signed(b[i+:8])) >>> 1);
                if (o == 4'h5) r[i+:8] = a[i+:8] - b[i+:8];
                if (o == 4'hb) r[i+:8] = a[i+:8] + b[i+:8];
            end
        endcase
        return r;
    endfunction
    task go(input logic [3:0] o, input int r);
        logic [31:0] a, b, t;
        logic c, g;
        logic [3:0] src, rd;
        int w, f;
        a = r == 0 ? 32'h8000_8080 : $urandom;
        b = r == 0 ? 32'h7fff_7f7f : $urandom;
        c = r == 0 || $urandom % 4 != 0;
        // upper indices are the stack pointer and program counter, never named
        src = $urandom % 13;
        rd = $urandom % 13;
        g = $urandom;
        t = o == 4'h8 ? a & b : a ^ b;
        w = rf.nw;
        f = rf.nf;
        if (c && (o < 8 || o == 10 || o == 11)) exp_q.push_back(mdl(o, a, b));
        @(posedge ref_clk);
        {issue, op, cond_pass, op_a, op_b} <= {1'b1, o, c, a, b};
        {first_idx, rd_idx, rd_given, shift_carry, flag_v_in} <= {src, rd, g, b[3], a[5]};
        @(posedge ref_clk);
        issue <= 0;
        @(posedge ref_clk);
        #1;
        check(rf.nw - w + 16 * (rf.nf - f), !c || o > 11 ? 0 : o == 8 || o == 9 ? 16 : 1);
        if (c && (o < 8 || o == 10 || o == 11)) check(rf.regs[g ? rd : src], exp_q.pop_front());
        if (c && (o == 8 || o == 9)) check(rf.psr, {28'h0, t[31], t == 0, b[3], a[5]});
    endtask
    initial begin
        void'($urandom(32'h0000_2477));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1;
        @(posedge ref_clk);
        #1;
        check({result_q[30:0], wr_en_q}, 32'h0);
        for (int r = 0; r < 40; r++) for (int o = 0; o < 16; o++) go(o[3:0], r);
        begin : frz
            int w0;
            // a frozen core must not take an op offered while the enable is low
            w0 = rf.nw;
            @(posedge ref_clk);
            {clk_en, issue, cond_pass, op} <= {1'b0, 1'b1, 1'b1, 4'h4};
            repeat (2) @(posedge ref_clk);
            {clk_en, issue} <= {1'b1, 1'b0};
            @(posedge ref_clk);
            #1;
            check(rf.nw - w0, 0);
        end
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop;
    end
endmodule
